// [rtl/aeo_out_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "aeo_cfg.svh"

// How it works
// - the angle goes out as a parallel word when the mode pin is low, serial plus incremental when high.
// - one turn is resolved into a 9-bit binary angle value.
// - parallel mode drives all nine bits on their own pins, bit 8 the msb and bit 0 the lsb.
// - serial mode turns pin 7 into the serial data out and takes the serial clock from the reader.
// - serial mode shows relative motion as two quadrature signals plus an index mark.
// - the quadrature outputs give 512 counts per mechanical turn.
// - while the hi-z request is high every digital pin is released.
// - the outputs keep up with the angle up to 30,000 rpm.
// - parallel pins refresh while hold is low and freeze while high; hold does nothing in serial mode.
// - mode, hi-z and hold inputs read low when left undriven.
module aeo_out_if
    import aeo_pkg::*;
#(
    parameter logic [7:0] QSTEP = 8'(`AEO_QSTEP_CYC),
    parameter logic [9:0] TOUT = 10'(`AEO_SSI_TOUT_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`AEO_POS_W-1:0] angle_in,
    input wire logic output_mode_sel,
    input wire logic output_hiz_req,
    input wire logic position_hold,
    input wire logic ssi_clk,
    output logic [`AEO_POS_W-1:0] pin_level,
    output logic [`AEO_POS_W-1:0] pin_oe
);
    aeo_state_t st_r;
    aeo_state_t st_nxt;

    logic mode_s;
    logic hiz_s;
    logic hold_s;
    logic sclk_rise;
    logic sclk_fall;
    logic quad_a;
    logic quad_b;
    logic index_hit;
    logic [`AEO_POS_W-1:0] diff;
    logic [`AEO_POS_W-1:0] load_word;

    aeo_stream_if #(.W(`AEO_POS_W)) s_in ();
    aeo_stream_if #(.W(`AEO_POS_W)) s_out ();

    // ----------------------------------------
    // synchronised pin levels
    // ----------------------------------------
    assign mode_s = st_r.sync2[`AEO_SY_MODE];
    assign hiz_s = st_r.sync2[`AEO_SY_HIZ];
    assign hold_s = st_r.sync2[`AEO_SY_HOLD];
    assign sclk_rise = st_r.sync2[`AEO_SY_SCLK] && !st_r.sclk_d;
    assign sclk_fall = !st_r.sync2[`AEO_SY_SCLK] && st_r.sclk_d;

    // ----------------------------------------
    // snapshot buffer for serial frames
    // ----------------------------------------
    assign s_in.data = st_r.samp;
    assign s_in.valid = st_r.samp_v;
    assign s_out.ready = (st_r.ssi == ssi_idle);
    assign load_word = s_out.valid ? s_out.data : st_r.samp;

    aeo_pair_buf #(
        .W(`AEO_POS_W),
        .DEPTH(2)
    ) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .up(s_in),
        .dn(s_out)
    );

    // ----------------------------------------
    // quadrature decode of the tracking count
    // ----------------------------------------
    assign diff = angle_in - st_r.qpos;
    assign quad_a = st_r.qpos[1];
    assign quad_b = st_r.qpos[1] ^ st_r.qpos[0];
    assign index_hit = (st_r.qpos == '0);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        // undriven pins are pulled low at the pads
        st_nxt.sync1 = {ssi_clk, position_hold, output_hiz_req,
            output_mode_sel};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sclk_d = st_r.sync2[`AEO_SY_SCLK];

        // source of the snapshot stream, stalls on a full buffer
        st_nxt.samp_v = 1'b1;
        if (s_in.ready || !st_r.samp_v) begin
            st_nxt.samp = angle_in;
        end

        // parallel word follows or freezes
        if (!mode_s && !hold_s) begin
            st_nxt.par = angle_in;
        end

        // step pacing for the incremental count
        st_nxt.step = 1'b0;
        if (st_r.div == QSTEP - 8'h01) begin
            st_nxt.div = 8'h00;
            st_nxt.step = 1'b1;
        end else begin
            st_nxt.div = st_r.div + 8'h01;
        end

        // one count per 1/512 turn, shortest way round
        if (st_r.step && diff != '0) begin
            if (diff[`AEO_POS_W-1]) begin
                st_nxt.qpos = st_r.qpos - 1'b1;
            end else begin
                st_nxt.qpos = st_r.qpos + 1'b1;
            end
        end

        // synchronous serial frame
        case (st_r.ssi)
            ssi_idle: begin
                st_nxt.dout = `AEO_RST_DOUT;
                st_nxt.bitcnt = 4'h0;
                st_nxt.tout = 10'h000;
                if (mode_s && sclk_fall) begin
                    st_nxt.ssi = ssi_frame;
                    st_nxt.shreg = load_word;
                end
            end
            ssi_frame: begin
                if (sclk_rise || sclk_fall) begin
                    st_nxt.tout = 10'h000;
                end else if (st_r.tout != TOUT) begin
                    st_nxt.tout = st_r.tout + 10'h001;
                end
                if (sclk_rise) begin
                    if (st_r.bitcnt != 4'(`AEO_POS_W)) begin
                        st_nxt.dout = st_r.shreg[`AEO_POS_W-1];
                        st_nxt.shreg = {st_r.shreg[`AEO_POS_W-2:0], 1'b0};
                        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                    end else begin
                        st_nxt.dout = 1'b0;
                    end
                end
                if (!mode_s || st_r.tout == TOUT) begin
                    st_nxt.ssi = ssi_idle;
                    st_nxt.dout = `AEO_RST_DOUT;
                end
            end
            default: begin
                st_nxt.ssi = ssi_idle;
            end
        endcase

        // pin multiplexing by mode
        if (!mode_s) begin
            st_nxt.pin_level = st_r.par;
            st_nxt.pin_oe = `AEO_PAR_OE_MASK;
        end else begin
            st_nxt.pin_level = '0;
            st_nxt.pin_level[`AEO_PIN_SSI] = st_r.dout;
            st_nxt.pin_level[`AEO_PIN_INCR1] = quad_a;
            st_nxt.pin_level[`AEO_PIN_INCR2] = quad_b;
            st_nxt.pin_level[`AEO_PIN_INDEX] = index_hit;
            st_nxt.pin_oe = `AEO_SER_OE_MASK;
        end
        if (hiz_s) begin
            st_nxt.pin_oe = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= AEO_ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_level = st_r.pin_level;
    assign pin_oe = st_r.pin_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_hiz_all_off: assert property (
        hiz_s |=> pin_oe == '0)
        else $error("pins driven during hi-z request");

    a_par_pin_map: assert property (
        (!mode_s && !hiz_s) |=>
            (pin_oe == `AEO_PAR_OE_MASK && pin_level == $past(st_r.par)))
        else $error("parallel pins do not show the word");

    a_par_tracks: assert property (
        (!mode_s && !hold_s) |=> st_r.par == $past(angle_in))
        else $error("parallel word not refreshed");

    a_hold_freeze: assert property (
        (!mode_s && hold_s) |=> $stable(st_r.par))
        else $error("parallel word moved while held");

    a_serial_pin_set: assert property (
        (mode_s && !hiz_s) |=> (pin_oe == `AEO_SER_OE_MASK &&
            pin_level[`AEO_PIN_SSI] == $past(st_r.dout)))
        else $error("serial pin set wrong");

    a_quad_gray: assert property (
        !($changed(quad_a) && $changed(quad_b)))
        else $error("both quadrature lines moved at once");

    a_step_paced: assert property (
        $changed(st_r.qpos) |-> $past(st_r.step))
        else $error("count moved without a step slot");

    a_index_at_zero: assert property (
        (mode_s && !hiz_s) |=>
            pin_level[`AEO_PIN_INDEX] == ($past(st_r.qpos) == '0))
        else $error("index mark not at zero");

    a_frame_capture: assert property (
        (st_r.ssi == ssi_idle && mode_s && sclk_fall) |=>
            (st_r.ssi == ssi_frame && st_r.shreg == $past(load_word)))
        else $error("frame start did not capture word");

    a_ssi_msb_first: assert property (
        (st_r.ssi == ssi_frame && sclk_rise && st_r.bitcnt == 4'h0 &&
            mode_s && st_r.tout != TOUT) |=>
            st_r.dout == $past(st_r.shreg[`AEO_POS_W-1]))
        else $error("first serial bit is not the msb");

    a_ser_spare_low: assert property (
        (mode_s && !hiz_s) |=>
            (pin_level & ~`AEO_SER_OE_MASK) == 9'h000)
        else $error("spare serial pins not low");

    a_ssi_tail_zero: assert property (
        (st_r.ssi == ssi_frame && sclk_rise && mode_s &&
            st_r.bitcnt == 4'(`AEO_POS_W) && st_r.tout != TOUT) |=>
            st_r.dout == 1'b0)
        else $error("serial data not low after the word");

    a_ssi_bit_step: assert property (
        (st_r.ssi == ssi_frame && sclk_rise && mode_s &&
            st_r.bitcnt != 4'(`AEO_POS_W) && st_r.tout != TOUT) |=>
            (st_r.dout == $past(st_r.shreg[`AEO_POS_W-1]) &&
            st_r.bitcnt == $past(st_r.bitcnt) + 4'h1))
        else $error("serial bit or count did not advance");

    a_ssi_idle_high: assert property (
        st_r.ssi == ssi_idle |=> st_r.dout == `AEO_RST_DOUT)
        else $error("serial data not high while idle");

    a_ssi_timeout: assert property (
        (st_r.ssi == ssi_frame && st_r.tout == TOUT) |=>
            (st_r.ssi == ssi_idle && st_r.dout == `AEO_RST_DOUT))
        else $error("frame not closed after quiet clock");

    a_ssi_mode_abort: assert property (
        (st_r.ssi == ssi_frame && !mode_s) |=> st_r.ssi == ssi_idle)
        else $error("frame kept running in parallel mode");

    a_bit_count_max: assert property (
        st_r.bitcnt <= 4'(`AEO_POS_W))
        else $error("serial bit count past the word");

    a_frame_start_clean: assert property (
        st_r.ssi == ssi_idle |=>
            (st_r.bitcnt == 4'h0 && st_r.tout == 10'h000))
        else $error("frame counters not cleared when idle");

    a_count_unit_step: assert property (
        $changed(st_r.qpos) |->
            (st_r.qpos == $past(st_r.qpos) + 9'h001 ||
            st_r.qpos == $past(st_r.qpos) - 9'h001))
        else $error("count moved by more than one");

    a_count_follows: assert property (
        (st_r.step && diff != '0) |=> $changed(st_r.qpos))
        else $error("count missed a step slot");

    a_step_spacing: assert property (
        st_r.step |-> $past(st_r.div) == QSTEP - 8'h01)
        else $error("step slot at wrong spacing");

    a_ser_hold_ignored: assert property (
        (mode_s && hold_s && s_in.ready) |=> st_r.samp == $past(angle_in))
        else $error("serial snapshot frozen by hold");

    c_hold_used: cover property (!mode_s && hold_s ##1 !hold_s);
    c_frame_done: cover property (st_r.ssi == ssi_frame &&
        st_r.bitcnt == 4'(`AEO_POS_W));
    c_index_seen: cover property (mode_s && index_hit);
    c_hiz_seen: cover property (hiz_s ##1 !hiz_s);
endmodule

`default_nettype wire

// [rtl/aeo_cfg.svh]
`ifndef AEO_CFG_SVH
`define AEO_CFG_SVH

// ----------------------------------------
// widths and pin positions
// ----------------------------------------
`define AEO_POS_W 9
`define AEO_PIN_MSB 8
`define AEO_PIN_SSI 7
`define AEO_PIN_INCR1 3
`define AEO_PIN_INDEX 2
`define AEO_PIN_INCR2 1
`define AEO_PIN_LSB 0
`define AEO_SER_OE_MASK 9'h08E
`define AEO_PAR_OE_MASK 9'h1FF

// ----------------------------------------
// synchroniser slots
// ----------------------------------------
`define AEO_SY_MODE 0
`define AEO_SY_HIZ 1
`define AEO_SY_HOLD 2
`define AEO_SY_SCLK 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define AEO_RST_DOUT 1'b1
`define AEO_RST_PINS 9'h000

// ----------------------------------------
// timing
// ----------------------------------------
`define AEO_CLK_HZ 64'd40000000
`define AEO_CLK_NS 25
`define AEO_CNT_PER_REV 64'd512
`define AEO_MAX_RPM 64'd30000
`define AEO_QSTEP_CYC \
    ((`AEO_CLK_HZ * 64'd60) / (`AEO_MAX_RPM * `AEO_CNT_PER_REV))
`define AEO_SSI_TOUT_NS 20000
`define AEO_SSI_TOUT_CYC (`AEO_SSI_TOUT_NS / `AEO_CLK_NS)

`endif

// [rtl/aeo_pkg.sv]
`include "aeo_cfg.svh"

package aeo_pkg;

    typedef enum logic {
        ssi_idle,
        ssi_frame
    } aeo_ssi_t;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic sclk_d;
        logic samp_v;
        logic [`AEO_POS_W-1:0] samp;
        logic [`AEO_POS_W-1:0] par;
        logic [`AEO_POS_W-1:0] qpos;
        logic [7:0] div;
        logic step;
        aeo_ssi_t ssi;
        logic [`AEO_POS_W-1:0] shreg;
        logic [3:0] bitcnt;
        logic [9:0] tout;
        logic dout;
        logic [`AEO_POS_W-1:0] pin_level;
        logic [`AEO_POS_W-1:0] pin_oe;
    } aeo_state_t;

    localparam aeo_state_t AEO_ST_RST = '{
        ssi: ssi_idle,
        dout: `AEO_RST_DOUT,
        pin_level: `AEO_RST_PINS,
        pin_oe: `AEO_RST_PINS,
        default: '0
    };

endpackage

// [rtl/aeo_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface aeo_stream_if #(
    parameter int W = 9
);
    logic [W-1:0] data;
    logic valid;
    logic ready;

    modport prod (
        output data,
        output valid,
        input ready
    );

    modport cons (
        input data,
        input valid,
        output ready
    );
endinterface

`default_nettype wire

// [rtl/aeo_pair_buf.sv]
`timescale 1ns/1ps
`default_nettype none

module aeo_pair_buf #(
    parameter int W = 9,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    aeo_stream_if.cons up,
    aeo_stream_if.prod dn
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } aeo_buf_t;

    aeo_buf_t st_r;
    aeo_buf_t st_nxt;
    logic push;
    logic pop;

    // ----------------------------------------
    // handshake
    // ----------------------------------------
    assign up.ready = (st_r.cnt != (AW+1)'(DEPTH));
    assign dn.valid = (st_r.cnt != '0);
    assign dn.data = st_r.mem[st_r.rp];
    assign push = up.valid && up.ready;
    assign pop = dn.valid && dn.ready;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = up.data;
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_buf_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.cnt <= (AW+1)'(DEPTH))
        else $error("buffer count above depth");
endmodule

`default_nettype wire

// [bench/aeo_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// reader: ssi clock, idle high
// ----------------------------------------
module aeo_host_model (
    input wire logic clk,
    input wire logic [8:0] pin_level,
    input wire logic [8:0] pin_oe,
    output logic ssi_clk
);
    logic last_r;

    initial begin
        ssi_clk = 1'b1;
        last_r = 1'b1;
    end

    task automatic read_frame(output logic [8:0] word);
        logic b;
        @(posedge clk);
        ssi_clk <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 8; i >= 0; i--) begin
            ssi_clk <= 1'b1;
            repeat (4) @(posedge clk);
            ssi_clk <= 1'b0;
            repeat (4) @(posedge clk);
            // released line is not trusted
            b = pin_oe[7] ? pin_level[7] : ~last_r;
            last_r = b;
            word[i] = b;
        end
        ssi_clk <= 1'b1;
    endtask
endmodule

`default_nettype wire

// [bench/angle_encoder_output_if_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module angle_encoder_output_if_tb;
    logic clk;
    logic rst_n;
    logic [8:0] angle_in;
    logic mode;
    logic hiz;
    logic hold;
    tri0 mode_pin;
    tri0 hiz_pin;
    tri0 hold_pin;
    logic ssi_clk;
    logic [8:0] pin_level;
    logic [8:0] pin_oe;
    logic [8:0] w;
    int failures = 0;
    int checks_done = 0;

    // pads pull floating inputs low
    assign mode_pin = mode;
    assign hiz_pin = hiz;
    assign hold_pin = hold;

    aeo_out_if #(.QSTEP(8'h04), .TOUT(10'h014)) u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .angle_in(angle_in),
        .output_mode_sel(mode_pin),
        .output_hiz_req(hiz_pin),
        .position_hold(hold_pin),
        .ssi_clk(ssi_clk),
        .pin_level(pin_level),
        .pin_oe(pin_oe)
    );

    aeo_host_model u_host (
        .clk(clk),
        .pin_level(pin_level),
        .pin_oe(pin_oe),
        .ssi_clk(ssi_clk)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [8:0] exp,
                       input logic [8:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_parallel;
        logic [8:0] v[4] = '{9'h100, 9'h001, 9'h155, 9'h0AA};
        mode <= 1'b0;
        foreach (v[i]) begin
            angle_in <= v[i];
            cyc(6);
            chk("par word", v[i], pin_level);
            chk("par oe", 9'h1FF, pin_oe);
        end
        $display("test parallel done");
    endtask

    task automatic test_hold;
        angle_in <= 9'h0F0;
        cyc(6);
        hold <= 1'b1;
        cyc(5);
        angle_in <= 9'h10F;
        cyc(6);
        chk("held word", 9'h0F0, pin_level);
        hold <= 1'b0;
        cyc(6);
        chk("refreshed word", 9'h10F, pin_level);
        $display("test hold done");
    endtask

    task automatic test_hiz;
        hiz <= 1'b1;
        cyc(6);
        chk("hiz oe par", 9'h000, pin_oe);
        mode <= 1'b1;
        cyc(6);
        chk("hiz oe ser", 9'h000, pin_oe);
        hiz <= 1'b0;
        mode <= 1'b0;
        cyc(6);
        chk("oe back", 9'h1FF, pin_oe);
        $display("test hiz done");
    endtask

    task automatic test_float;
        angle_in <= 9'h0C3;
        mode <= 1'bz;
        hiz <= 1'bz;
        hold <= 1'bz;
        cyc(6);
        chk("float word", 9'h0C3, pin_level);
        chk("float oe", 9'h1FF, pin_oe);
        mode <= 1'b0;
        hiz <= 1'b0;
        hold <= 1'b0;
        $display("test float done");
    endtask

    task automatic test_serial;
        logic [8:0] v[2] = '{9'h1A5, 9'h05A};
        mode <= 1'b1;
        hold <= 1'b1;
        foreach (v[i]) begin
            angle_in <= v[i];
            cyc(40);
            chk("ser oe", 9'h08E, pin_oe);
            chk("ser idle", 9'h001, {8'h00, pin_level[7]});
            u_host.read_frame(w);
            chk("ser word", v[i], w);
            cyc(8);
            chk("ser tail", 9'h000, {8'h00, pin_level[7]});
            cyc(40);
            chk("ser end", 9'h001, {8'h00, pin_level[7]});
        end
        hold <= 1'b0;
        $display("test serial done");
    endtask

    task automatic test_incr;
        logic [8:0] v[6] = '{9'h001, 9'h002, 9'h003, 9'h000, 9'h1FF, 9'h000};
        logic [8:0] e;
        mode <= 1'b1;
        foreach (v[i]) begin
            angle_in <= v[i];
            cyc(1200);
            e = {5'h00, v[i][1], v[i] == 9'h000, v[i][1] ^ v[i][0], 1'b0};
            chk("quad pins", e, pin_level & 9'h00E);
        end
        $display("test incremental done");
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        angle_in = 9'h000;
        mode = 1'b0;
        hiz = 1'b0;
        hold = 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(4);
        test_parallel();
        test_hold();
        test_hiz();
        test_float();
        test_serial();
        test_incr();
        stop_test();
    end

    initial begin
        #(25 * 30000);
        failures++;
        $display("watchdog expired");
        stop_test();
    end
endmodule

`default_nettype wire
